// >>> pdr_param_store.sv
// parameter store with dependent re-initialisation behind an AXI4-Lite slave
// Behaviour
// - class change reloads band and hysteresis defaults
// - class change reloads alarm hysteresis, except MV
// - alarm becomes MV kind: hysteresis 50
// - alarm leaves MV kind: hysteresis 2
// - autotuning hysteresis 0.8 Celsius, 1.4 Fahrenheit
// - self-tuning on forces local setpoint, remote off
// - self-tuning condition met does the same
// - remote setpoint off forces local setpoint
// - control mode change reloads MV limits
// - heating/cooling assigns cooling output
// - pattern off: aux1 heater alarm or alarm1
// - pattern not off: aux1 program end
// - pattern off unassigns program-start event inputs
// - robust tuning on, temperature input: sets 0.1 s unit
// - PID reload: band 8.0, 233, 40
// - change to analog with robust tuning: reload, tuning off
// - transfer limits follow transfer output type
// - range changes reload SP/PV transfer limits
// - control mode change reloads MV transfer limits
// - transfer type change always reloads limits
// - remote limits from input or scaling range
// - password change copies into protect password
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module pdr_param_store #(
  parameter bit HAS_CTRL_OUT2 = 1'b1,
  parameter bit HAS_FOUR_AUX  = 1'b0,
  parameter bit HAS_HB_HS     = 1'b1
) (
  input  wire logic                       REF_CLK,
  input  wire logic                       RST_N,
  input  wire logic [pdr_pkg::AW-1:0]     S_AXI_AWADDR,
  input  wire logic                       S_AXI_AWVALID,
  output logic                            S_AXI_AWREADY,
  input  wire logic [31:0]                S_AXI_WDATA,
  input  wire logic [3:0]                 S_AXI_WSTRB,
  input  wire logic                       S_AXI_WVALID,
  output logic                            S_AXI_WREADY,
  output logic [1:0]                      S_AXI_BRESP,
  output logic                            S_AXI_BVALID,
  input  wire logic                       S_AXI_BREADY,
  input  wire logic [pdr_pkg::AW-1:0]     S_AXI_ARADDR,
  input  wire logic                       S_AXI_ARVALID,
  output logic                            S_AXI_ARREADY,
  output logic [31:0]                     S_AXI_RDATA,
  output logic [1:0]                      S_AXI_RRESP,
  output logic                            S_AXI_RVALID,
  input  wire logic                       S_AXI_RREADY,
  input  wire logic                       ST_COND_MET,
  output logic                            SP_REMOTE_SEL,
  output logic                            HEAT_COOL_SEL
);
  import pdr_pkg::*;

  pdr_word_t   mem_r   [NREG];
  pdr_word_t   mem_nxt [NREG];
  pdr_word_t   mem_w   [NREG];

  logic        aw_full_r, aw_full_nxt;
  pdr_idx_t    aw_idx_r, aw_idx_nxt;
  logic        aw_ok_r, aw_ok_nxt;
  logic        w_full_r, w_full_nxt;
  pdr_word_t   wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  pdr_word_t   rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic        st_cond_q_r, st_cond_q_nxt;
  logic        wr_go;

  // handshake outputs are flops or inverted flops, data comes from flops
  assign S_AXI_AWREADY = !aw_full_r;
  assign S_AXI_WREADY  = !w_full_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;
  assign SP_REMOTE_SEL = mem_r[IDX_SPSRC][SPMOD_BIT];
  assign HEAT_COOL_SEL = mem_r[IDX_CMODE][HC_BIT];

  // write applies only once address and data are both held and the
  // previous response is gone, so one write is in flight at a time
  assign wr_go = aw_full_r && w_full_r && !bvalid_r;

  // bus channel state
  always_comb
  begin
    aw_full_nxt = aw_full_r;
    aw_idx_nxt  = aw_idx_r;
    aw_ok_nxt   = aw_ok_r;
    w_full_nxt  = w_full_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (S_AXI_AWVALID && !aw_full_r)
    begin
      aw_full_nxt = 1'b1;
      aw_idx_nxt  = S_AXI_AWADDR[AW-1:2];
      aw_ok_nxt   = (S_AXI_AWADDR[AW-1:2] < NREG_IX);
    end
    if (S_AXI_WVALID && !w_full_r)
    begin
      w_full_nxt = 1'b1;
      wdata_nxt  = S_AXI_WDATA;
      wstrb_nxt  = S_AXI_WSTRB;
    end
    if (S_AXI_BREADY && bvalid_r)
      bvalid_nxt = 1'b0;
    // response raised in the cycle the store and its reloads commit
    // atomic write commit
    if (wr_go)
    begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = aw_ok_r ? RESP_OKAY : RESP_SLVERR;
    end
    if (S_AXI_RREADY && rvalid_r)
      rvalid_nxt = 1'b0;
    // unmapped reads answer zero with an error
    if (S_AXI_ARVALID && !rvalid_r)
    begin
      rvalid_nxt = 1'b1;
      if (S_AXI_ARADDR[AW-1:2] < NREG_IX)
      begin
        rdata_nxt = mem_r[S_AXI_ARADDR[AW-1:2]];
        rresp_nxt = RESP_OKAY;
      end
      else
      begin
        rdata_nxt = V_0;
        rresp_nxt = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      aw_full_r <= 1'b0;
      aw_idx_r  <= 6'h00;
      aw_ok_r   <= 1'b0;
      w_full_r  <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      aw_idx_r  <= aw_idx_nxt;
      aw_ok_r   <= aw_ok_nxt;
      w_full_r  <= w_full_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // parameter store: raw write first, then every dependent reload is
  // folded into the same next value, so no read ever sees half a set
  always_comb
  begin
    logic       an_old;
    logic       an_new;
    logic       class_chg;
    logic       unit_f;
    logic       hit;
    logic       rt_reload;
    logic [3:0] xt;
    logic [3:0] at_old;
    logic [3:0] at_new;
    pdr_word_t  in_hi;
    pdr_word_t  in_lo;
    an_old    = 1'b0;
    an_new    = 1'b0;
    class_chg = 1'b0;
    unit_f    = 1'b0;
    hit       = 1'b0;
    rt_reload = 1'b0;
    xt        = 4'h0;
    at_old    = 4'h0;
    at_new    = 4'h0;
    in_hi     = V_0;
    in_lo     = V_0;
    mem_w     = mem_r;
    st_cond_q_nxt = ST_COND_MET;
    // byte lanes of the raw write
    if (wr_go && aw_ok_r)
      for (int b = 0; b < 4; b++)
        if (wstrb_r[b])
          mem_w[aw_idx_r][8*b +: 8] = wdata_r[8*b +: 8];
    mem_nxt = mem_w;

    an_old    = mem_r[IDX_INTYPE][INTYPE_W-1:0] >= ANALOG_FIRST;
    an_new    = mem_w[IDX_INTYPE][INTYPE_W-1:0] >= ANALOG_FIRST;
    class_chg = an_old != an_new;
    unit_f    = mem_w[IDX_TUNIT][UNIT_BIT];
    hit       = wr_go && aw_ok_r;
    xt        = mem_w[IDX_XTYPE][FW-1:0];
    in_hi     = an_new ? mem_w[IDX_SCL_HI] : INR_HI;
    in_lo     = an_new ? mem_w[IDX_SCL_LO] : INR_LO;

    if (class_chg)
    begin
      mem_nxt[IDX_DEADB]  = an_new ? DEADB_A : DEADB_T;
      mem_nxt[IDX_HYSH]   = an_new ? HYS_A   : HYS_T;
      mem_nxt[IDX_HYSC]   = an_new ? HYS_A   : HYS_T;
      mem_nxt[IDX_WAITB]  = an_new ? WAITB_A : WAITB_T;
      mem_nxt[IDX_STSTAB] = an_new ? STST_A  : STST_T;
      mem_nxt[IDX_LBALV]  = an_new ? LBALV_A : LBALV_T;
      mem_nxt[IDX_LBABD]  = an_new ? LBABD_A : LBABD_T;
    end
    if (class_chg || (mem_r[IDX_TUNIT][UNIT_BIT] != unit_f))
      mem_nxt[IDX_ATHYS] = unit_f ? ATHYS_F : ATHYS_C;

    // alarm hysteresis, per alarm
    for (int a = 0; a < N_ALARM; a++)
    begin
      at_old = mem_r[IDX_ALMTYP][FW*a +: FW];
      at_new = mem_w[IDX_ALMTYP][FW*a +: FW];
      if (class_chg && at_new != ALM_MV_HI && at_new != ALM_MV_LO)
        mem_nxt[IDX_AHYS0 + 6'(a)] = an_new ? AHYS_A : AHYS_T;
      if ((at_old != ALM_MV_HI && at_old != ALM_MV_LO) && (at_new == ALM_MV_HI || at_new == ALM_MV_LO))
        mem_nxt[IDX_AHYS0 + 6'(a)] = AHYS_MV;
      if ((at_old == ALM_MV_HI || at_old == ALM_MV_LO) && (at_new != ALM_MV_HI && at_new != ALM_MV_LO))
        mem_nxt[IDX_AHYS0 + 6'(a)] = AHYS_NONMV;
    end

    if (!an_new && !mem_r[IDX_TUNE][RT_BIT] && mem_w[IDX_TUNE][RT_BIT])
    begin
      mem_nxt[IDX_TUNE][TU_BIT] = 1'b1;
      rt_reload = 1'b1;
    end
    if (an_new && !an_old && mem_w[IDX_TUNE][RT_BIT])
    begin
      mem_nxt[IDX_TUNE][RT_BIT] = 1'b0;
      mem_nxt[IDX_TUNE][TU_BIT] = 1'b0;
      rt_reload = 1'b1;
    end
    if (rt_reload)
    begin
      mem_nxt[IDX_PBH] = PB_DEF;
      mem_nxt[IDX_PBC] = PB_DEF;
      mem_nxt[IDX_TIH] = mem_nxt[IDX_TUNE][TU_BIT] ? TI_01S : TI_1S;
      mem_nxt[IDX_TIC] = mem_nxt[IDX_TUNE][TU_BIT] ? TI_01S : TI_1S;
      mem_nxt[IDX_TDH] = mem_nxt[IDX_TUNE][TU_BIT] ? TD_01S : TD_1S;
      mem_nxt[IDX_TDC] = mem_nxt[IDX_TUNE][TU_BIT] ? TD_01S : TD_1S;
    end

    if (mem_r[IDX_SPSRC][RSPEN_BIT] && !mem_w[IDX_SPSRC][RSPEN_BIT])
      mem_nxt[IDX_SPSRC][SPMOD_BIT] = 1'b0;
    if (!mem_r[IDX_TUNE][ST_BIT] && mem_w[IDX_TUNE][ST_BIT])
    begin
      mem_nxt[IDX_SPSRC][SPMOD_BIT] = 1'b0;
      mem_nxt[IDX_SPSRC][RSPEN_BIT] = 1'b0;
    end
    if (ST_COND_MET && !st_cond_q_r)
    begin
      mem_nxt[IDX_SPSRC][SPMOD_BIT] = 1'b0;
      mem_nxt[IDX_SPSRC][RSPEN_BIT] = 1'b0;
    end

    if (mem_r[IDX_CMODE][HC_BIT] != mem_w[IDX_CMODE][HC_BIT])
    begin
      mem_nxt[IDX_MVHI] = V_1000;
      mem_nxt[IDX_MVLO] = mem_w[IDX_CMODE][HC_BIT] ? V_NEG1000 : V_0;
      // standard control falls back to the reset assignment
      mem_nxt[IDX_OUTASG] = REG_RST[IDX_OUTASG];
      if (mem_w[IDX_CMODE][HC_BIT])
      begin
        if (HAS_CTRL_OUT2)
          mem_nxt[IDX_OUTASG][OA_CO2 +: FW] = FN_COOL;
        else if (HAS_FOUR_AUX)
          mem_nxt[IDX_OUTASG][OA_AUX4 +: FW] = FN_COOL;
        else
          mem_nxt[IDX_OUTASG][OA_AUX2 +: FW] = FN_COOL;
      end
    end

    // any write of the program pattern re-decides auxiliary output 1
    if (hit && aw_idx_r == IDX_PPAT)
    begin
      if (mem_w[IDX_PPAT] == PPAT_OFF)
        mem_nxt[IDX_OUTASG][OA_AUX1 +: FW] = HAS_HB_HS ? FN_HEATER : FN_ALARM1;
      else
        mem_nxt[IDX_OUTASG][OA_AUX1 +: FW] = FN_PROG_END;
    end
    if (mem_r[IDX_PPAT] != PPAT_OFF && mem_w[IDX_PPAT] == PPAT_OFF)
      for (int e = 0; e < N_EVENT; e++)
        if (mem_w[IDX_EVASG][FW*e +: FW] == EV_PROG_START)
          mem_nxt[IDX_EVASG][FW*e +: FW] = EV_NONE;

    if ((hit && (aw_idx_r <= IDX_SPL_HI) && (xt == XT_SP || xt == XT_RSP || xt == XT_PV))
        || ((mem_r[IDX_CMODE][HC_BIT] != mem_w[IDX_CMODE][HC_BIT]) && (xt == XT_MVH || xt == XT_MVC))
        || (mem_r[IDX_XTYPE] != mem_w[IDX_XTYPE]))
    begin
      if (xt == XT_SP || xt == XT_RSP)
      begin
        mem_nxt[IDX_XHI] = mem_w[IDX_SPL_HI];
        mem_nxt[IDX_XLO] = mem_w[IDX_SPL_LO];
      end
      else if (xt == XT_PV)
      begin
        mem_nxt[IDX_XHI] = in_hi;
        mem_nxt[IDX_XLO] = in_lo;
      end
      else
      begin
        mem_nxt[IDX_XHI] = V_1000;
        mem_nxt[IDX_XLO] = V_0;
      end
    end

    if (hit && aw_idx_r <= IDX_SCL_HI)
    begin
      mem_nxt[IDX_RSPHI] = in_hi;
      mem_nxt[IDX_RSPLO] = in_lo;
    end

    if (mem_r[IDX_PASSWD] != mem_w[IDX_PASSWD])
      mem_nxt[IDX_PROTPW] = mem_w[IDX_PASSWD];
  end

  // storage flops, reset to the documented defaults
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      mem_r       <= REG_RST;
      st_cond_q_r <= 1'b0;
    end
    else
    begin
      mem_r       <= mem_nxt;
      st_cond_q_r <= st_cond_q_nxt;
    end
  end

endmodule

// >>> pdr_param_store_properties.sv
// checker of handshake and update timing at the parameter store's ports
`timescale 1ns/10ps
module pdr_param_store_properties
  import pdr_pkg::*;
(
  input wire logic                   REF_CLK,
  input wire logic                   RST_N,
  input wire logic [pdr_pkg::AW-1:0] S_AXI_AWADDR,
  input wire logic                   S_AXI_AWVALID,
  input wire logic                   S_AXI_AWREADY,
  input wire logic [31:0]            S_AXI_WDATA,
  input wire logic [3:0]             S_AXI_WSTRB,
  input wire logic                   S_AXI_WVALID,
  input wire logic                   S_AXI_WREADY,
  input wire logic [1:0]             S_AXI_BRESP,
  input wire logic                   S_AXI_BVALID,
  input wire logic                   S_AXI_BREADY,
  input wire logic [pdr_pkg::AW-1:0] S_AXI_ARADDR,
  input wire logic                   S_AXI_ARVALID,
  input wire logic                   S_AXI_ARREADY,
  input wire logic [31:0]            S_AXI_RDATA,
  input wire logic [1:0]             S_AXI_RRESP,
  input wire logic                   S_AXI_RVALID,
  input wire logic                   S_AXI_RREADY,
  input wire logic                   ST_COND_MET,
  input wire logic                   SP_REMOTE_SEL,
  input wire logic                   HEAT_COOL_SEL
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // answers stand until the master takes them
  chk_b_held: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  chk_r_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  chk_ar_ready: assert property (S_AXI_ARREADY == !S_AXI_RVALID)
    else $error("read address ready not tied to read valid");
  chk_aw_busy: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("write address accepted before commit");
  chk_b_timing: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      && !S_AXI_BVALID |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write response not two cycles after handshake");
  chk_r_timing: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  chk_rd_unmapped: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:2] >= NREG_IX
      |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  chk_st_clear: assert property ($rose(ST_COND_MET) |=> !SP_REMOTE_SEL)
    else $error("remote setpoint kept after tuning condition");
  // mode output moves only as a write commits
  chk_hc_commit: assert property ($changed(HEAT_COOL_SEL) |-> !$past(S_AXI_AWREADY))
    else $error("control mode changed without a write");
endmodule

// >>> pdr_pkg.sv
// package for the parameter store with dependent re-initialisation
package pdr_pkg;

  typedef logic [31:0] pdr_word_t;
  typedef logic [5:0]  pdr_idx_t;

  localparam int       NREG    = 40;
  localparam int       AW      = 8;
  localparam pdr_idx_t NREG_IX = 6'h28;

  // register indices; byte address is four times the index
  localparam pdr_idx_t IDX_INTYPE = 6'h00, IDX_TUNIT  = 6'h01, IDX_SCL_LO = 6'h02, IDX_SCL_HI = 6'h03;
  localparam pdr_idx_t IDX_SPL_LO = 6'h04, IDX_SPL_HI = 6'h05, IDX_CMODE  = 6'h06, IDX_PPAT   = 6'h07;
  localparam pdr_idx_t IDX_TUNE   = 6'h08, IDX_SPSRC  = 6'h09, IDX_XTYPE  = 6'h0A, IDX_ALMTYP = 6'h0B;
  localparam pdr_idx_t IDX_PASSWD = 6'h0C, IDX_PROTPW = 6'h0D, IDX_OUTASG = 6'h0E, IDX_EVASG  = 6'h0F;
  localparam pdr_idx_t IDX_DEADB  = 6'h10, IDX_HYSH   = 6'h11, IDX_HYSC   = 6'h12, IDX_WAITB  = 6'h13;
  localparam pdr_idx_t IDX_STSTAB = 6'h14, IDX_ATHYS  = 6'h15, IDX_LBALV  = 6'h16, IDX_LBABD  = 6'h17;
  localparam pdr_idx_t IDX_AHYS0  = 6'h18;
  localparam pdr_idx_t IDX_MVHI   = 6'h1C, IDX_MVLO   = 6'h1D, IDX_XHI    = 6'h1E, IDX_XLO    = 6'h1F;
  localparam pdr_idx_t IDX_RSPHI  = 6'h20, IDX_RSPLO  = 6'h21, IDX_PBH    = 6'h22, IDX_PBC    = 6'h23;
  localparam pdr_idx_t IDX_TIH    = 6'h24, IDX_TIC    = 6'h25, IDX_TDH    = 6'h26, IDX_TDC    = 6'h27;

  // field positions
  localparam int INTYPE_W  = 5;
  localparam int ST_BIT    = 0;
  localparam int RT_BIT    = 1;
  localparam int TU_BIT    = 2;   // 1 selects 0.1 s time unit
  localparam int RSPEN_BIT = 0;
  localparam int SPMOD_BIT = 1;   // 1 selects remote setpoint
  localparam int HC_BIT    = 0;
  localparam int UNIT_BIT  = 0;   // 1 selects Fahrenheit
  localparam int FW        = 4;   // function / type nibble width
  localparam int OA_CO2    = 0;
  localparam int OA_AUX1   = 4;
  localparam int OA_AUX2   = 8;
  localparam int OA_AUX4   = 12;
  localparam int N_ALARM   = 4;
  localparam int N_EVENT   = 6;

  // codes
  localparam logic [4:0]  ANALOG_FIRST  = 5'h19;
  localparam logic [3:0]  ALM_MV_HI     = 4'hE, ALM_MV_LO = 4'hF;
  localparam logic [3:0]  FN_NONE       = 4'h0, FN_COOL = 4'h1, FN_ALARM1 = 4'h2, FN_HEATER = 4'h3;
  localparam logic [3:0]  FN_PROG_END   = 4'h4, FN_ALARM2 = 4'h6;
  localparam logic [3:0]  EV_NONE       = 4'h0, EV_PROG_START = 4'h3;
  localparam logic [31:0] PPAT_OFF      = 32'h0000_0000;
  localparam logic [3:0]  XT_SP = 4'h0, XT_RSP = 4'h1, XT_PV = 4'h2, XT_MVH = 4'h3, XT_MVC = 4'h4;

  // fixed values, tenths where the value has one decimal
  localparam pdr_word_t V_1000     = 32'h0000_03E8;
  localparam pdr_word_t V_0        = 32'h0000_0000;
  localparam pdr_word_t V_NEG1000  = 32'hFFFF_FC18;
  localparam pdr_word_t AHYS_MV    = 32'h0000_0032;
  localparam pdr_word_t AHYS_NONMV = 32'h0000_0002;
  localparam pdr_word_t ATHYS_C    = 32'h0000_0008;
  localparam pdr_word_t ATHYS_F    = 32'h0000_000E;
  localparam pdr_word_t PB_DEF     = 32'h0000_0050;
  localparam pdr_word_t TI_1S      = 32'h0000_00E9, TI_01S = 32'h0000_091A;
  localparam pdr_word_t TD_1S      = 32'h0000_0028, TD_01S = 32'h0000_0190;

  // class dependent defaults: temperature / analog
  localparam pdr_word_t DEADB_T = 32'h0000_0000, DEADB_A = 32'h0000_0000;
  localparam pdr_word_t HYS_T   = 32'h0000_0008, HYS_A   = 32'h0000_000A;
  localparam pdr_word_t WAITB_T = 32'h0000_0000, WAITB_A = 32'h0000_0000;
  localparam pdr_word_t STST_T  = 32'h0000_000F, STST_A  = 32'h0000_000F;
  localparam pdr_word_t LBALV_T = 32'h0000_0050, LBALV_A = 32'h0000_0064;
  localparam pdr_word_t LBABD_T = 32'h0000_0030, LBABD_A = 32'h0000_0014;
  localparam pdr_word_t AHYS_T  = 32'h0000_0002, AHYS_A  = 32'h0000_0002;
  localparam pdr_word_t INR_HI  = 32'h0000_0514, INR_LO  = 32'hFFFF_FF38;

  localparam logic [1:0] RESP_OKAY = 2'b00, RESP_SLVERR = 2'b10;

  localparam pdr_word_t REG_RST [NREG] = '{
    32'h0000_0005, 32'h0000_0000, 32'h0000_0064, 32'h0000_0000,
    INR_LO,        INR_HI,        32'h0000_0000, PPAT_OFF,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_6020, 32'h0000_0000,
    DEADB_T,       HYS_T,         HYS_T,         WAITB_T,
    STST_T,        ATHYS_C,       LBALV_T,       LBABD_T,
    AHYS_T,        AHYS_T,        AHYS_T,        AHYS_T,
    V_1000,        V_0,           INR_HI,        INR_LO,
    INR_HI,        INR_LO,        PB_DEF,        PB_DEF,
    TI_1S,         TI_1S,         TD_1S,         TD_1S};

endpackage

// >>> tb_pdr_param_store.sv
// self-checking bench for the parameter store through its AXI4-Lite port
`timescale 1ns/10ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_pdr_param_store;
  import pdr_pkg::*;
  logic          REF_CLK, RST_N, ST_COND_MET, SP_REMOTE_SEL, HEAT_COOL_SEL;
  logic [AW-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic          S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic          S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [31:0]   S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]    S_AXI_WSTRB;
  logic [1:0]    S_AXI_BRESP, S_AXI_RRESP, rsp;
  pdr_word_t     q;
  int            bad_count, total_checks, cycles;
  // analog class defaults, then PID set for the 0.1 s unit
  localparam pdr_word_t CLS_A [8] = '{DEADB_A, HYS_A, HYS_A, WAITB_A, STST_A, ATHYS_F, LBALV_A, LBABD_A};
  localparam pdr_word_t PID01 [6] = '{PB_DEF, PB_DEF, TI_01S, TI_01S, TD_01S, TD_01S};

  pdr_param_store u_pdr_param_store (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .ST_COND_MET(ST_COND_MET), .SP_REMOTE_SEL(SP_REMOTE_SEL), .HEAT_COOL_SEL(HEAT_COOL_SEL));

  // 40 MHz clock
  initial
  begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end

  // verdict and counts, the only way out of the run
  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge REF_CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  // one write; address and data offered together, each dropped once taken
  task automatic wr(input pdr_idx_t ix, input pdr_word_t d, input logic [3:0] sb = 4'hF);
    logic aw_left, w_left;
    @(posedge REF_CLK);
    S_AXI_AWADDR <= {ix, 2'h0};
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= sb;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    // values read right after the edge are those the slave saw there
    while (aw_left || w_left)
    begin
      @(posedge REF_CLK);
      if (aw_left && S_AXI_AWREADY === 1'b1)
      begin
        aw_left = 1'b0;
        S_AXI_AWVALID <= 1'b0;
      end
      if (w_left && S_AXI_WREADY === 1'b1)
      begin
        w_left = 1'b0;
        S_AXI_WVALID <= 1'b0;
      end
    end
    while (S_AXI_BVALID !== 1'b1)
      @(posedge REF_CLK);
    rsp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask

  // one read into q and rsp
  task automatic rd(input pdr_idx_t ix);
    @(posedge REF_CLK);
    S_AXI_ARADDR <= {ix, 2'h0};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge REF_CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge REF_CLK); while (S_AXI_RVALID !== 1'b1);
    q = S_AXI_RDATA;
    rsp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask

  task automatic ck(input pdr_idx_t ix, input pdr_word_t exp);
    rd(ix);
    `CHK(q, exp)
  endtask

  initial
  begin
    {RST_N, ST_COND_MET, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    S_AXI_WSTRB = 4'hF;
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    // reset table, then refused places
    for (int i = 0; i < NREG; i++)
      ck(pdr_idx_t'(i), REG_RST[i]);
    rd(6'h28);
    `CHK({rsp, q}, {RESP_SLVERR, 32'h0})
    wr(6'h3F, 32'h1);
    `CHK(rsp, RESP_SLVERR)
    $display("test reset and map done");
    // setpoint pair: no setpoint words stored, so never split
    // control mode and transfer limits, temperature input
    wr(IDX_XTYPE, 32'(XT_MVH));
    ck(IDX_XHI, V_1000);
    wr(IDX_XHI, 32'h5);
    wr(IDX_MVHI, 32'h5);
    wr(IDX_CMODE, 32'h1);
    `CHK(rsp, RESP_OKAY)
    ck(IDX_MVHI, V_1000);
    ck(IDX_MVLO, V_NEG1000);
    ck(IDX_XHI, V_1000);
    ck(IDX_OUTASG, 32'h6021);
    `CHK(HEAT_COOL_SEL, 1'b1)
    wr(IDX_CMODE, 32'h0);
    ck(IDX_MVLO, V_0);
    wr(IDX_SPL_HI, 32'h400);
    ck(IDX_XHI, V_1000);
    wr(IDX_XTYPE, 32'(XT_SP));
    ck(IDX_XHI, 32'h400);
    ck(IDX_XLO, INR_LO);
    wr(IDX_SPL_HI, 32'h300);
    ck(IDX_XHI, 32'h300);
    wr(IDX_XTYPE, 32'(XT_PV));
    ck(IDX_XHI, INR_HI);
    $display("test mode and transfer done");
    // setpoint source forced to local
    wr(IDX_SPSRC, 32'h3);
    `CHK(SP_REMOTE_SEL, 1'b1)
    wr(IDX_SPSRC, 32'h2);
    ck(IDX_SPSRC, 32'h0);
    wr(IDX_SPSRC, 32'h3);
    wr(IDX_TUNE, 32'h1);
    ck(IDX_SPSRC, 32'h0);
    wr(IDX_SPSRC, 32'h3);
    @(posedge REF_CLK);
    ST_COND_MET <= 1'b1;
    @(posedge REF_CLK);
    ST_COND_MET <= 1'b0;
    ck(IDX_SPSRC, 32'h0);
    `CHK(SP_REMOTE_SEL, 1'b0)
    $display("test setpoint source done");
    // robust tuning on a temperature input
    wr(IDX_PBH, 32'h1);
    wr(IDX_TUNE, 32'h2);
    ck(IDX_TUNE, 32'h6);
    for (int i = 0; i < 6; i++)
      ck(pdr_idx_t'(34 + i), PID01[i]);
    $display("test tuning done");
    // password copy, full word then one byte lane
    wr(IDX_PASSWD, 32'h1234);
    ck(IDX_PROTPW, 32'h1234);
    wr(IDX_PASSWD, 32'hAB, 4'h1);
    ck(IDX_PASSWD, 32'h12AB);
    ck(IDX_PROTPW, 32'h12AB);
    $display("test password done");
    // program pattern drives aux 1 and event inputs
    wr(IDX_EVASG, 32'h30_0203);
    wr(IDX_PPAT, 32'h1);
    rd(IDX_OUTASG);
    `CHK(q[7:4], FN_PROG_END)
    wr(IDX_PPAT, 32'h0);
    rd(IDX_OUTASG);
    `CHK(q[7:4], FN_HEATER)
    ck(IDX_EVASG, 32'h200);
    $display("test pattern done");
    // alarm kinds, unit and class switch
    wr(IDX_ALMTYP, 32'hE);
    ck(IDX_AHYS0, AHYS_MV);
    wr(IDX_RSPHI, 32'h5);
    wr(IDX_TUNIT, 32'h1);
    ck(IDX_ATHYS, ATHYS_F);
    ck(IDX_RSPHI, INR_HI);
    for (int i = 16; i < 26; i++)
      wr(pdr_idx_t'(i), 32'h7);
    wr(IDX_INTYPE, 32'h19);
    for (int i = 0; i < 8; i++)
      ck(pdr_idx_t'(16 + i), CLS_A[i]);
    // MV alarm keeps the value written just before the class switch
    ck(IDX_AHYS0, 32'h7);
    ck(6'h19, AHYS_A);
    ck(IDX_TUNE, 32'h0);
    ck(IDX_TIH, TI_1S);
    wr(IDX_ALMTYP, 32'h0);
    ck(IDX_AHYS0, AHYS_NONMV);
    $display("test class switch done");
    close_out();
  end
endmodule

bind pdr_param_store pdr_param_store_properties u_pdr_param_store_properties (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .ST_COND_MET(ST_COND_MET), .SP_REMOTE_SEL(SP_REMOTE_SEL), .HEAT_COOL_SEL(HEAT_COOL_SEL));
